// ==== rtl/gpc_pin_controller.sv ====
// General pin controller: 37 pins, function mux, change interrupts, Avalon-MM slave
`timescale 1ns/1ps
module gpc_pin_controller
   import gpc_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter logic [3:0] MGMT_STRAP_CODE = 4'h1
) (
   // Clock and reset
   input wire logic SYS_CLK_IN,
   input wire logic RESET_N_IN,
   // Avalon-MM register slave
   input wire logic [ADDR_W-1:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   input wire logic [3:0] AVS_BYTEENABLE_IN,
   output logic [31:0] AVS_READDATA_OUT,
   output logic AVS_WAITREQUEST_OUT,
   // Pin side
   input wire logic [36:0] PIN_IN,
   output logic [36:0] PIN_OUT,
   output logic [36:0] PIN_OE_OUT,
   // Alternate function drivers
   input wire logic [36:0] ALT1_OUT_IN,
   input wire logic [36:0] ALT1_OE_IN,
   input wire logic [36:0] ALT2_OUT_IN,
   input wire logic [36:0] ALT2_OE_IN,
   input wire logic [36:0] ALT3_OUT_IN,
   input wire logic [36:0] ALT3_OE_IN,
   // Function select and strap results
   output logic [36:0] FUNC_SEL0_OUT,
   output logic [36:0] FUNC_SEL1_OUT,
   output logic [3:0] CPU_CONFIG_STRAPS_OUT,
   // Management slave data driver
   input wire logic MGMT_SLAVE_DATA_OUT_IN,
   input wire logic MGMT_SLAVE_DATA_OE_IN,
   output logic MGMT_SLAVE_MODE_OUT,
   // Interrupt
   output logic IRQ_OUT
);

   if (ADDR_W < 8) begin : g_addr_check
      $error("ADDR_W too small for the register map");
   end

   logic [36:0] out_val;
   logic [36:0] oe;
   logic [36:0] sel0;
   logic [36:0] sel1;
   logic [36:0] ena;
   logic [36:0] flags;
   logic [36:0] active;
   logic [36:0] clear;
   logic [36:0] wbits;
   logic [36:0] wmask;
   logic [36:0] mux_out;
   logic [36:0] mux_oe;
   logic [36:0] pin_q;
   logic [36:0] chg;
   logic [31:0] be_mask;
   logic [31:0] wdata;
   logic [31:0] next_rdata;
   logic [4:0] idx;
   logic [3:0] straps;
   logic hi;
   logic wr_en;
   logic rd_take;
   logic soft_rst;
   logic reg_rst_n;
   logic mgmt_mode;
   logic any_active;

   // Low or high word of a 37-bit register
   function automatic logic [31:0] pick(input logic [36:0] v, input logic h);
      pick = h ? {27'h000_0000, v[36:32]} : v[31:0];
   endfunction : pick

   // Bus decode; a write lands at the edge that shows waitrequest low
   assign idx = AVS_ADDRESS_IN[7:3];
   assign hi = AVS_ADDRESS_IN[2];
   assign wr_en = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;
   assign rd_take = AVS_READ_IN && AVS_WAITREQUEST_OUT;
   assign be_mask = {{8{AVS_BYTEENABLE_IN[3]}}, {8{AVS_BYTEENABLE_IN[2]}},
                     {8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};
   assign wdata = AVS_WRITEDATA_IN & be_mask;
   assign wbits = hi ? {wdata[4:0], 32'h0000_0000} : {5'h00, wdata};
   assign wmask = hi ? {be_mask[4:0], 32'h0000_0000} : {5'h00, be_mask};

   // Software block reset spares the function select and the straps
   assign reg_rst_n = RESET_N_IN && !soft_rst;

   // One wait cycle per request, then one ready cycle
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN) begin
         AVS_WAITREQUEST_OUT <= 1'b1;
      end else if ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT) begin
         AVS_WAITREQUEST_OUT <= 1'b0;
      end else begin
         AVS_WAITREQUEST_OUT <= 1'b1;
      end
   end

   // Read mux; unmapped addresses read as zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (idx)
         GPC_IDX_OUT: next_rdata = pick(out_val, hi);
         GPC_IDX_IN: next_rdata = pick(PIN_IN, hi);
         GPC_IDX_OE: next_rdata = pick(oe, hi);
         GPC_IDX_SEL0: next_rdata = pick(sel0, hi);
         GPC_IDX_SEL1: next_rdata = pick(sel1, hi);
         GPC_IDX_FLAGS: next_rdata = pick(flags, hi);
         GPC_IDX_ENA: next_rdata = pick(ena, hi);
         GPC_IDX_ACTIVE: next_rdata = pick(active, hi);
         GPC_IDX_CTRL: begin
            if (!hi) begin
               next_rdata[GPC_CTRL_MGMT_BIT] = mgmt_mode;
               next_rdata[GPC_CTRL_STRAP_LSB +: GPC_STRAP_W] = straps;
            end
         end
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Read data is captured with the request and stands through the ready cycle
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN) begin
         AVS_READDATA_OUT <= 32'h0000_0000;
      end else if (rd_take) begin
         AVS_READDATA_OUT <= next_rdata;
      end
   end

   // Soft reset pulse from the control word
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN) begin
         soft_rst <= 1'b0;
      end else begin
         soft_rst <= wr_en && idx == GPC_IDX_CTRL && !hi && wdata[GPC_CTRL_SOFT_RST_BIT];
      end
   end

   // Output value with plain, atomic set and atomic clear writes
   always_ff @(posedge SYS_CLK_IN) begin
      if (!reg_rst_n) begin
         out_val <= GPC_OUT_RST;
      end else if (wr_en && idx == GPC_IDX_OUT) begin
         out_val <= (out_val & ~wmask) | wbits;
      end else if (wr_en && idx == GPC_IDX_SET) begin
         out_val <= out_val | wbits;
      end else if (wr_en && idx == GPC_IDX_CLR) begin
         out_val <= out_val & ~wbits;
      end
   end

   // Output enables, all inputs after reset
   always_ff @(posedge SYS_CLK_IN) begin
      if (!reg_rst_n) begin
         oe <= GPC_OE_RST;
      end else if (wr_en && idx == GPC_IDX_OE) begin
         oe <= (oe & ~wmask) | wbits;
      end
   end

   // Function select only follows the device reset
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN) begin
         sel0 <= GPC_SEL_RST;
         sel1 <= GPC_SEL_RST;
      end else begin
         if (wr_en && idx == GPC_IDX_SEL0) begin
            sel0 <= (sel0 & ~wmask) | wbits;
         end
         if (wr_en && idx == GPC_IDX_SEL1) begin
            sel1 <= (sel1 & ~wmask) | wbits;
         end
      end
   end

   // Strap capture while reset is held; pins are ordinary once released
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN) begin
         straps <= PIN_IN[GPC_STRAP_LSB +: GPC_STRAP_W];
      end
   end

   // Management slave mode follows the captured straps
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN) begin
         mgmt_mode <= 1'b0;
      end else begin
         mgmt_mode <= straps == MGMT_STRAP_CODE;
      end
   end

   // Interrupt enables
   always_ff @(posedge SYS_CLK_IN) begin
      if (!reg_rst_n) begin
         ena <= GPC_ENA_RST;
      end else if (wr_en && idx == GPC_IDX_ENA) begin
         ena <= (ena & ~wmask) | wbits;
      end
   end

   // Write one to a flag clears it
   assign clear = (wr_en && idx == GPC_IDX_FLAGS) ? wbits : '0;

   gpc_change_flags #(
      .N(GPC_PINS)
   ) u_flags (
      .clk_in(SYS_CLK_IN),
      .rst_n_in(reg_rst_n),
      .level_in(PIN_IN),
      .clear_in(clear),
      .flags_out(flags)
   );

   assign active = flags & ena;
   assign any_active = |active;

   // One function mux per pin, with fixed function presence
   for (genvar i = 0; i < GPC_PINS; i++) begin : g_pin
      gpc_pin_mux #(
         .HAS_F2(GPC_F2_MASK[i]),
         .HAS_F3(GPC_F3_MASK[i])
      ) u_mux (
         .func_in(gpc_func_t'({sel1[i], sel0[i]})),
         .plain_out_in(out_val[i]),
         .plain_oe_in(oe[i]),
         .alt1_out_in(ALT1_OUT_IN[i]),
         .alt1_oe_in(ALT1_OE_IN[i]),
         .alt2_out_in(ALT2_OUT_IN[i]),
         .alt2_oe_in(ALT2_OE_IN[i]),
         .alt3_out_in(ALT3_OUT_IN[i]),
         .alt3_oe_in(ALT3_OE_IN[i]),
         .pin_out(mux_out[i]),
         .pin_oe_out(mux_oe[i])
      );
   end

   // Pin drivers, registered; management slave overrides pins 22 and 23
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN) begin
         PIN_OUT <= '0;
         PIN_OE_OUT <= '0;
      end else begin
         PIN_OUT <= mux_out;
         PIN_OE_OUT <= mux_oe;
         if (mgmt_mode) begin
            PIN_OUT[GPC_MGMT_CLK_PIN] <= 1'b0;
            PIN_OE_OUT[GPC_MGMT_CLK_PIN] <= 1'b0;
            PIN_OUT[GPC_MGMT_DATA_PIN] <= MGMT_SLAVE_DATA_OUT_IN;
            PIN_OE_OUT[GPC_MGMT_DATA_PIN] <= MGMT_SLAVE_DATA_OE_IN;
         end
      end
   end

   // Status outputs
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN) begin
         FUNC_SEL0_OUT <= '0;
         FUNC_SEL1_OUT <= '0;
         CPU_CONFIG_STRAPS_OUT <= 4'h0;
         MGMT_SLAVE_MODE_OUT <= 1'b0;
         IRQ_OUT <= 1'b0;
      end else begin
         FUNC_SEL0_OUT <= sel0;
         FUNC_SEL1_OUT <= sel1;
         CPU_CONFIG_STRAPS_OUT <= straps;
         MGMT_SLAVE_MODE_OUT <= mgmt_mode;
         IRQ_OUT <= any_active;
      end
   end

   // Helper history for the checks below
   always_ff @(posedge SYS_CLK_IN) begin
      pin_q <= PIN_IN;
   end
   assign chg = PIN_IN ^ pin_q;

   oe_reset_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      !$past(RESET_N_IN) |-> oe == '0 && PIN_OE_OUT == '0)
      else $error("output enables not cleared by reset");

   set_ones_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      wr_en && idx == GPC_IDX_SET |=>
      (out_val & $past(wbits)) == $past(wbits)
      && ((out_val ^ $past(out_val)) & ~$past(wbits)) == '0)
      else $error("atomic set changed the wrong bits");

   clear_ones_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      wr_en && idx == GPC_IDX_CLR |=>
      (out_val & $past(wbits)) == '0
      && ((out_val ^ $past(out_val)) & ~$past(wbits)) == '0)
      else $error("atomic clear changed the wrong bits");

   level_read_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      rd_take && idx == GPC_IDX_IN && !hi |=>
      AVS_READDATA_OUT == $past(PIN_IN[31:0]) && !AVS_WAITREQUEST_OUT)
      else $error("level register does not show the pins");

   plain_drive_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      sel0[8] == 1'b0 && sel1[8] == 1'b0 |=>
      PIN_OE_OUT[8] == $past(oe[8]) && (!PIN_OE_OUT[8] || PIN_OUT[8] == $past(out_val[8])))
      else $error("plain pin not driven from output value");

   select_keep_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      soft_rst |=> sel0 == $past(sel0) && sel1 == $past(sel1) && oe == '0)
      else $error("soft reset disturbed the function select");

   change_flag_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!reg_rst_n)
      $past(reg_rst_n) && $past(reg_rst_n, 2) |->
      (flags & $past(chg)) == $past(chg))
      else $error("input change did not set its flag");

   flag_sticky_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!reg_rst_n)
      reg_rst_n && !(wr_en && idx == GPC_IDX_FLAGS) |=> (flags & $past(flags)) == $past(flags))
      else $error("flag dropped without a clear");

   irq_follow_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      1'b1 |=> IRQ_OUT == |($past(flags) & $past(ena)))
      else $error("interrupt does not follow enabled flags");

   active_read_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      rd_take && idx == GPC_IDX_ACTIVE && !hi |=>
      AVS_READDATA_OUT == ($past(flags[31:0]) & $past(ena[31:0])))
      else $error("active register is not flags and enables");

   mgmt_take_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      mgmt_mode |=> !PIN_OE_OUT[GPC_MGMT_CLK_PIN]
      && PIN_OE_OUT[GPC_MGMT_DATA_PIN] == $past(MGMT_SLAVE_DATA_OE_IN))
      else $error("management slave did not take its pins");

   alt3_route_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      sel0[5] && sel1[5] |=> PIN_OE_OUT[5] == $past(ALT3_OE_IN[5]))
      else $error("code three did not route third function");

endmodule : gpc_pin_controller

// ==== pkg/gpc_pkg.sv ====
// Shared constants and types of the general pin controller
package gpc_pkg;

   // Pin count and special pin positions
   localparam int GPC_PINS = 37;
   localparam int GPC_STRAP_LSB = 33;
   localparam int GPC_STRAP_W = 4;
   localparam int GPC_MGMT_CLK_PIN = 22;
   localparam int GPC_MGMT_DATA_PIN = 23;

   // Register index (byte address bits 7:3); address bit 2 picks the high word
   localparam logic [4:0] GPC_IDX_OUT = 5'h00;
   localparam logic [4:0] GPC_IDX_SET = 5'h01;
   localparam logic [4:0] GPC_IDX_CLR = 5'h02;
   localparam logic [4:0] GPC_IDX_IN = 5'h03;
   localparam logic [4:0] GPC_IDX_OE = 5'h04;
   localparam logic [4:0] GPC_IDX_SEL0 = 5'h05;
   localparam logic [4:0] GPC_IDX_SEL1 = 5'h06;
   localparam logic [4:0] GPC_IDX_FLAGS = 5'h07;
   localparam logic [4:0] GPC_IDX_ENA = 5'h08;
   localparam logic [4:0] GPC_IDX_ACTIVE = 5'h09;
   localparam logic [4:0] GPC_IDX_CTRL = 5'h0a;

   // Control word field positions
   localparam int GPC_CTRL_SOFT_RST_BIT = 0;
   localparam int GPC_CTRL_MGMT_BIT = 1;
   localparam int GPC_CTRL_STRAP_LSB = 4;

   // Reset values
   localparam logic [36:0] GPC_OUT_RST = 37'h00_0000_0000;
   localparam logic [36:0] GPC_OE_RST = 37'h00_0000_0000;
   localparam logic [36:0] GPC_SEL_RST = 37'h00_0000_0000;
   localparam logic [36:0] GPC_ENA_RST = 37'h00_0000_0000;
   localparam logic [36:0] GPC_FLAGS_RST = 37'h00_0000_0000;

   // Pins that own a second and a third alternate function
   localparam logic [36:0] GPC_F2_MASK = 37'h00_1edd_ff30;
   localparam logic [36:0] GPC_F3_MASK = 37'h00_1edf_ff30;

   // Function select codes
   typedef enum logic [1:0] {
      GPC_FUNC_PLAIN = 2'b00,
      GPC_FUNC_ALT1 = 2'b01,
      GPC_FUNC_ALT2 = 2'b10,
      GPC_FUNC_ALT3 = 2'b11
   } gpc_func_t;

endpackage : gpc_pkg

// ==== rtl/gpc_pin_mux.sv ====
// Per-pin function multiplexer of the general pin controller
`timescale 1ns/1ps
module gpc_pin_mux
   import gpc_pkg::*;
#(
   parameter bit HAS_F2 = 1'b1,
   parameter bit HAS_F3 = 1'b1
) (
   // Selection
   input wire gpc_func_t func_in,
   // Candidate drivers
   input wire logic plain_out_in,
   input wire logic plain_oe_in,
   input wire logic alt1_out_in,
   input wire logic alt1_oe_in,
   input wire logic alt2_out_in,
   input wire logic alt2_oe_in,
   input wire logic alt3_out_in,
   input wire logic alt3_oe_in,
   // Result
   output logic pin_out,
   output logic pin_oe_out
);

   // A missing function leaves the pin undriven rather than guess a driver
   always_comb begin
      pin_out = 1'b0;
      pin_oe_out = 1'b0;
      unique case (func_in)
         GPC_FUNC_PLAIN: begin
            pin_out = plain_out_in;
            pin_oe_out = plain_oe_in;
         end
         GPC_FUNC_ALT1: begin
            pin_out = alt1_out_in;
            pin_oe_out = alt1_oe_in;
         end
         GPC_FUNC_ALT2: begin
            pin_out = HAS_F2 & alt2_out_in;
            pin_oe_out = HAS_F2 & alt2_oe_in;
         end
         GPC_FUNC_ALT3: begin
            pin_out = HAS_F3 & alt3_out_in;
            pin_oe_out = HAS_F3 & alt3_oe_in;
         end
      endcase
   end

endmodule : gpc_pin_mux

// ==== rtl/gpc_change_flags.sv ====
// Sticky change-detect flags with write-one-to-clear
`timescale 1ns/1ps
module gpc_change_flags #(
   parameter int N = 37
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Watched levels and clear strobe
   input wire logic [N-1:0] level_in,
   input wire logic [N-1:0] clear_in,
   // Sticky flags
   output logic [N-1:0] flags_out
);

   if (N < 1) begin : g_n_check
      $error("N must be at least one");
   end

   logic [N-1:0] prev;
   logic armed;
   logic [N-1:0] change;

   // No history right after reset, so the first cycle compares nothing
   assign change = armed ? (level_in ^ prev) : '0;

   // Previous level and arming
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         prev <= '0;
         armed <= 1'b0;
      end else begin
         prev <= level_in;
         armed <= 1'b1;
      end
   end

   // A new change beats a clear in the same cycle
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         flags_out <= '0;
      end else begin
         flags_out <= (flags_out & ~clear_in) | change;
      end
   end

endmodule : gpc_change_flags

// ==== tb/gpc_board_model.sv ====
// Board model: external signals seen by the pin controller
`timescale 1ns/1ps
module gpc_board_model
   import gpc_pkg::*;
(
   // Device side
   input wire logic [36:0] pin_drv_in,
   input wire logic [36:0] pin_oe_in,
   // Board side
   input wire logic [36:0] ext_level_in,
   output logic [36:0] pin_level_out
);
   // Each wire shows the device value while driven, else the board keeper level;
   // the keeper stands in for the board's own drivers, so no wire ever floats
   always_comb begin
      pin_level_out = (pin_drv_in & pin_oe_in) | (ext_level_in & ~pin_oe_in);
   end
endmodule : gpc_board_model

// ==== tb/tb_top.sv ====
// Top testbench of the general pin controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_total++; \
   $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module tb_top
   import gpc_pkg::*;
;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata;
   logic waitreq;
   logic [36:0] pin_in;
   logic [36:0] pin_out;
   logic [36:0] pin_oe;
   logic [36:0] ext = 37'h02_0080_005a;
   logic [36:0] sel0;
   logic [36:0] sel1;
   logic [3:0] straps;
   logic mgmt_mode;
   logic irq;
   logic [31:0] rd;
   int err_total = 0;
   int checked = 0;
   // Alternate drivers: one output/enable pattern per function so the mux choice shows
   localparam logic [3:0] FN_O = 4'b1010;
   localparam logic [3:0] FN_E = 4'b0110;

   gpc_pin_controller dut (
      .SYS_CLK_IN(sys_clk), .RESET_N_IN(reset_n),
      .AVS_ADDRESS_IN(address), .AVS_READ_IN(read), .AVS_WRITE_IN(write),
      .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'hf),
      .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq),
      .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_OUT(pin_oe),
      .ALT1_OUT_IN({37{1'b1}}), .ALT1_OE_IN({37{1'b1}}),
      .ALT2_OUT_IN({37{1'b0}}), .ALT2_OE_IN({37{1'b1}}),
      .ALT3_OUT_IN({37{1'b1}}), .ALT3_OE_IN({37{1'b0}}),
      .FUNC_SEL0_OUT(sel0), .FUNC_SEL1_OUT(sel1), .CPU_CONFIG_STRAPS_OUT(straps),
      .MGMT_SLAVE_DATA_OUT_IN(1'b1), .MGMT_SLAVE_DATA_OE_IN(1'b1),
      .MGMT_SLAVE_MODE_OUT(mgmt_mode), .IRQ_OUT(irq)
   );

   gpc_board_model board (
      .pin_drv_in(pin_out), .pin_oe_in(pin_oe), .ext_level_in(ext), .pin_level_out(pin_in)
   );

   // Clock of 5 ns
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end

   // Avalon write: request held until waitrequest is seen low at a rising edge
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      address <= a;
      wdata <= d;
      write <= 1'b1;
      // No cycle count is assumed; only the watchdog ends a stuck wait
      do begin
         @(posedge sys_clk);
      end while (waitreq !== 1'b0);
      write <= 1'b0;
      @(posedge sys_clk);
   endtask : bus_wr

   // Avalon read: data taken at the same edge that shows waitrequest low
   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      address <= a;
      read <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (waitreq !== 1'b0);
      d = rdata;
      read <= 1'b0;
      @(posedge sys_clk);
   endtask : bus_rd

   // Verdict and end of run
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up

   // Watchdog well beyond the fewer than two hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      wrap_up();
   end

   // Test sequence
   initial begin
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      // Straps change after release and must not be taken again
      ext[36:33] <= 4'ha;
      repeat (3) @(posedge sys_clk);
      `CHK("pin_oe", 37'h00_0080_0000, pin_oe)
      `CHK("straps", 4'h1, straps)
      `CHK("mgmt_mode", 1'b1, mgmt_mode)
      `CHK("pin23_out", 1'b1, pin_out[23])
      bus_rd(8'h20, rd);
      `CHK("oe_reg", 32'h0000_0000, rd)
      bus_rd(8'h50, rd);
      `CHK("ctrl", 32'h0000_0012, rd)
      $display("test reset done");

      // Output value, atomic set and clear, direction and input levels
      bus_wr(8'h00, 32'h0000_00f0);
      bus_wr(8'h08, 32'h0000_0f00);
      bus_rd(8'h00, rd);
      `CHK("out_set", 32'h0000_0ff0, rd)
      bus_wr(8'h10, 32'h0000_0030);
      bus_rd(8'h00, rd);
      `CHK("out_clr", 32'h0000_0fc0, rd)
      bus_wr(8'h0c, 32'h0000_0010);
      bus_rd(8'h04, rd);
      `CHK("out_hi_set", 32'h0000_0010, rd)
      bus_wr(8'h14, 32'h0000_0010);
      bus_rd(8'h04, rd);
      `CHK("out_hi_clr", 32'h0000_0000, rd)
      bus_wr(8'h20, 32'h0000_ff00);
      repeat (2) @(posedge sys_clk);
      `CHK("pin_oe_lo", 32'h0080_ff00, pin_oe[31:0])
      `CHK("pin_out_lo", 8'h0f, pin_out[15:8])
      bus_rd(8'h18, rd);
      `CHK("in_reg", 32'h0080_0f5a, rd)
      bus_rd(8'h08, rd);
      `CHK("set_reads0", 32'h0000_0000, rd)
      $display("test output done");

      // Every function code on pin 5, then a missing function on pin 17
      for (int c = 0; c < 4; c++) begin
         bus_wr(8'h28, {26'h0, c[0], 5'h00});
         bus_wr(8'h30, {26'h0, c[1], 5'h00});
         repeat (2) @(posedge sys_clk);
         `CHK("fn_out", FN_O[c], pin_out[5])
         `CHK("fn_oe", FN_E[c], pin_oe[5])
      end
      bus_wr(8'h30, 32'h0002_0020);
      repeat (2) @(posedge sys_clk);
      `CHK("fn_missing", 1'b0, pin_oe[17])
      // Software block reset keeps the function map
      bus_wr(8'h50, 32'h0000_0001);
      repeat (3) @(posedge sys_clk);
      bus_rd(8'h30, rd);
      `CHK("sel1_kept", 32'h0002_0020, rd)
      `CHK("sel0_pins", 1'b1, sel0[5])
      `CHK("sel1_pins", 1'b1, sel1[17])
      bus_rd(8'h20, rd);
      `CHK("oe_softrst", 32'h0000_0000, rd)
      $display("test function done");

      // Change flags, enables, masking and write-one clearing
      bus_wr(8'h38, 32'hffff_ffff);
      bus_wr(8'h3c, 32'h0000_001f);
      bus_wr(8'h40, 32'h0000_0200);
      ext[9] <= 1'b1;
      repeat (3) @(posedge sys_clk);
      `CHK("irq_on", 1'b1, irq)
      ext[10] <= 1'b1;
      repeat (3) @(posedge sys_clk);
      bus_rd(8'h38, rd);
      `CHK("flags", 32'h0000_0600, rd)
      bus_rd(8'h48, rd);
      `CHK("active", 32'h0000_0200, rd)
      bus_wr(8'h40, 32'h0000_0000);
      repeat (2) @(posedge sys_clk);
      `CHK("irq_masked", 1'b0, irq)
      bus_wr(8'h38, 32'h0000_0200);
      bus_rd(8'h38, rd);
      `CHK("flag_w1c", 32'h0000_0400, rd)
      bus_wr(8'h40, 32'h0000_0400);
      repeat (2) @(posedge sys_clk);
      `CHK("irq_sticky", 1'b1, irq)
      bus_wr(8'h38, 32'h0000_0400);
      repeat (2) @(posedge sys_clk);
      `CHK("irq_clear", 1'b0, irq)
      bus_rd(8'hf8, rd);
      `CHK("unmapped", 32'h0000_0000, rd)
      $display("test interrupt done");
      wrap_up();
   end
endmodule : tb_top
